// file: src/smp_pkg.sv
// Constants, types and register map of the serial byte port.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone master.
`default_nettype none

package smp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA  = 8'h3C;
    localparam logic [7:0] IDX_CFG   = 8'h3D;
    localparam logic [7:0] IDX_STAT  = 8'h3E;
    localparam logic [7:0] IDX_CLAIM = 8'h3F;

    localparam logic [7:0] RST_DATA  = 8'h00;
    localparam logic [7:0] RST_CFG   = 8'h00;
    localparam logic [3:0] RST_CLAIM = 4'h0;

    // Status register fields
    localparam int STAT_RXCNT_LO = 0;
    localparam int STAT_TXFULL   = 2;
    localparam int STAT_BUSY     = 3;

    // Role encodings
    localparam logic [1:0] ROLE_OFF    = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE  = 2'h2;

    // Divisors of the processor core clock per serial clock period
    localparam int DIV_SEL0 = 6;
    localparam int DIV_SEL1 = 12;
    localparam int DIV_SEL2 = 48;
    localparam int DIV_SEL3 = 96;

    // Pin indices along the four consecutive port pins
    localparam int PIN_MOSI = 0;
    localparam int PIN_SEL  = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SCLK = 3;

    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [1:0] RX_DEPTH  = 2'h2;

    typedef struct packed {
        logic       swap;
        logic       lsb_first;
        logic [1:0] role;
        logic       cpol;
        logic       cpha;
        logic [1:0] sclk_sel;
    } smp_cfg_s;

    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe_n;
    } smp_pins_s;

    typedef enum logic {SMP_IDLE, SMP_SHIFT} smp_state_e;

endpackage : smp_pkg

`default_nettype wire

// file: src/smp_spi_port.sv
// Serial byte port, master or slave, behind a Wishbone slave.
// Assumes pin inputs are asynchronous and port logic supplies GPIO defaults.
`default_nettype none

module smp_spi_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  pin_i,
    output logic      [3:0]  pin_o,
    output logic      [3:0]  pin_oe_n_o,
    input  wire logic [3:0]  port_lvl_i,
    input  wire logic [3:0]  port_oe_n_i,
    output logic             rx_ready_evt_o,
    output logic             tx_empty_evt_o
);

    function automatic logic [5:0] half_cnt(input logic [1:0] sel);
        int d;
        case (sel)
            2'h0:    d = smp_pkg::DIV_SEL0;
            2'h1:    d = smp_pkg::DIV_SEL1;
            2'h2:    d = smp_pkg::DIV_SEL2;
            default: d = smp_pkg::DIV_SEL3;
        endcase
        half_cnt = 6'(d / 2 - 1);
    endfunction : half_cnt

    smp_pkg::smp_cfg_s   cfg_r;
    logic [3:0]          claim_r;
    logic [7:0]          tx_hold_r;
    logic                tx_full_r;
    logic [7:0]          rx_mem_r [2];
    logic                wp_r;
    logic                rp_r;
    logic [1:0]          rx_cnt_r;
    logic [3:0]          s1_r;
    logic [3:0]          s2_r;
    logic [3:0]          s3_r;
    smp_pkg::smp_state_e state_r;
    smp_pkg::smp_state_e state_nxt;
    logic [7:0]          tx_sh_r;
    logic [7:0]          tx_sh_nxt;
    logic [7:0]          rx_sh_r;
    logic [7:0]          rx_sh_nxt;
    logic [3:0]          ecnt_r;
    logic [3:0]          ecnt_nxt;
    logic [5:0]          hc_r;
    logic [5:0]          hc_nxt;
    logic                sclk_r;
    logic                sclk_nxt;
    logic                done;
    logic                load;
    logic                samp_r;
    logic                fin_r;
    logic                ack_r;
    logic [31:0]         dat_r;
    logic                rx_evt_r;
    logic                tx_evt_r;
    smp_pkg::smp_pins_s  pins_r;
    smp_pkg::smp_pins_s  pins_nxt;

    // Bus decode
    wire        acc     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire [7:0]  idx     = {2'h0, wb_adr_i[7:2]};
    wire        wr      = acc & wb_we_i & wb_sel_i[0];
    wire        rd      = acc & ~wb_we_i;
    wire        wr_data = wr & (idx == smp_pkg::IDX_DATA);
    wire        wr_cfg  = wr & (idx == smp_pkg::IDX_CFG);
    wire        wr_clm  = wr & (idx == smp_pkg::IDX_CLAIM);
    wire        rd_data = rd & (idx == smp_pkg::IDX_DATA);

    // Role and link decode
    wire        master  = cfg_r.role == smp_pkg::ROLE_MASTER;
    wire        slave   = cfg_r.role == smp_pkg::ROLE_SLAVE;
    wire        enabled = master | slave;
    wire        busy    = state_r == smp_pkg::SMP_SHIFT;
    wire        sel_act = slave & ~s2_r[smp_pkg::PIN_SEL];
    wire [5:0]  half    = half_cnt(cfg_r.sclk_sel);
    wire        m_edge  = master & busy & (hc_r == 6'h00);
    wire        s_edge  = slave & busy & (s2_r[smp_pkg::PIN_SCLK] ^ s3_r[smp_pkg::PIN_SCLK]);
    wire        edge_ev = m_edge | s_edge;
    wire        new_lvl = master ? ~sclk_r : s2_r[smp_pkg::PIN_SCLK];
    wire        lead    = new_lvl != cfg_r.cpol;
    wire        drv_mo  = master ^ cfg_r.swap;
    wire        din     = drv_mo ? s2_r[smp_pkg::PIN_MISO] : s2_r[smp_pkg::PIN_MOSI];
    wire        dout    = cfg_r.lsb_first ? tx_sh_r[0] : tx_sh_r[7];
    wire        rx_room = rx_cnt_r != smp_pkg::RX_DEPTH;
    wire        start   = (master & tx_full_r & rx_room & ~fin_r) | sel_act;
    wire        nz_edge = ecnt_r != 4'h0;
    wire        launch  = edge_ev & (cfg_r.cpha ? (lead & nz_edge) : ~lead);
    wire        sample  = edge_ev & (cfg_r.cpha ? ~lead : lead);
    wire        last    = edge_ev & (ecnt_r == smp_pkg::LAST_EDGE);
    wire        abort   = ~enabled | (slave & s2_r[smp_pkg::PIN_SEL]);
    wire        push    = fin_r & rx_room;
    wire        pop     = rd_data & (rx_cnt_r != 2'h0);
    wire [7:0]  rx_head = rx_mem_r[rp_r];
    wire [7:0]  stat    = {4'h0, busy, tx_full_r, rx_cnt_r};
    wire [31:0] rd_mux  = (idx == smp_pkg::IDX_DATA)  ? {24'h0, rx_head} :
                          (idx == smp_pkg::IDX_CFG)   ? {24'h0, cfg_r} :
                          (idx == smp_pkg::IDX_STAT)  ? {24'h0, stat} :
                          (idx == smp_pkg::IDX_CLAIM) ? {28'h0, claim_r} : 32'h0;

    // Shift engine
    always_comb begin
        state_nxt = state_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        ecnt_nxt  = ecnt_r;
        hc_nxt    = hc_r;
        sclk_nxt  = sclk_r;
        done      = 1'b0;
        load      = 1'b0;
        case (state_r)
            smp_pkg::SMP_IDLE: begin
                sclk_nxt = cfg_r.cpol;
                if (enabled & start) begin
                    state_nxt = smp_pkg::SMP_SHIFT;
                    tx_sh_nxt = tx_full_r ? tx_hold_r : 8'h00;
                    load      = tx_full_r;
                    ecnt_nxt  = 4'h0;
                    hc_nxt    = half;
                end
            end
            smp_pkg::SMP_SHIFT: begin
                if (abort) begin
                    state_nxt = smp_pkg::SMP_IDLE;
                end else begin
                    if (master) begin
                        hc_nxt = (hc_r == 6'h00) ? half : hc_r - 6'h01;
                    end
                    if (m_edge) begin
                        sclk_nxt = ~sclk_r;
                    end
                    if (launch) begin
                        tx_sh_nxt = cfg_r.lsb_first ? {1'b0, tx_sh_r[7:1]}
                                                    : {tx_sh_r[6:0], 1'b0};
                    end
                    if (edge_ev) begin
                        ecnt_nxt = ecnt_r + 4'h1;
                    end
                    if (last) begin
                        done      = 1'b1;
                        state_nxt = smp_pkg::SMP_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = smp_pkg::SMP_IDLE;
            end
        endcase
        // Sample a cycle late so the returned bit has passed the synchroniser
        if (samp_r) begin
            rx_sh_nxt = cfg_r.lsb_first ? {din, rx_sh_r[7:1]}
                                        : {rx_sh_r[6:0], din};
        end
    end

    // Pin ownership and direction
    always_comb begin
        logic [3:0] ser_lvl;
        logic [3:0] ser_oe_n;
        logic       dat_drv;
        ser_lvl  = 4'h0;
        ser_oe_n = 4'hF;
        dat_drv  = master | sel_act;
        ser_lvl[smp_pkg::PIN_SCLK]  = sclk_r;
        ser_oe_n[smp_pkg::PIN_SCLK] = ~master;
        ser_lvl[smp_pkg::PIN_MOSI]  = dout;
        ser_oe_n[smp_pkg::PIN_MOSI] = ~(drv_mo & dat_drv);
        ser_lvl[smp_pkg::PIN_MISO]  = dout;
        ser_oe_n[smp_pkg::PIN_MISO] = ~(~drv_mo & dat_drv);
        ser_lvl[smp_pkg::PIN_SEL]   = master ? ~(busy | fin_r) : port_lvl_i[smp_pkg::PIN_SEL];
        ser_oe_n[smp_pkg::PIN_SEL]  = port_oe_n_i[smp_pkg::PIN_SEL];
        for (int i = 0; i < 4; i++) begin
            if (claim_r[i] & enabled) begin
                pins_nxt.lvl[i]  = ser_lvl[i];
                pins_nxt.oe_n[i] = ser_oe_n[i];
            end else begin
                pins_nxt.lvl[i]  = port_lvl_i[i];
                pins_nxt.oe_n[i] = port_oe_n_i[i];
            end
        end
    end

    // Pin input synchronisers
    always_ff @(posedge clk_i) begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= smp_pkg::SMP_IDLE;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            ecnt_r  <= 4'h0;
            hc_r    <= 6'h00;
            sclk_r  <= 1'b0;
            samp_r  <= 1'b0;
            fin_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            ecnt_r  <= ecnt_nxt;
            hc_r    <= hc_nxt;
            sclk_r  <= sclk_nxt;
            samp_r  <= sample & ~abort;
            fin_r   <= done;
        end
    end

    // Configuration and claim registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r   <= smp_pkg::RST_CFG;
            claim_r <= smp_pkg::RST_CLAIM;
        end else begin
            if (wr_cfg) begin
                cfg_r <= wb_dat_i[7:0];
            end
            if (wr_clm) begin
                claim_r <= wb_dat_i[3:0];
            end
        end
    end

    // Transmit holding register; a write wins over the load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_hold_r <= smp_pkg::RST_DATA;
            tx_full_r <= 1'b0;
        end else if (wr_data) begin
            tx_hold_r <= wb_dat_i[7:0];
            tx_full_r <= 1'b1;
        end else if (load) begin
            tx_full_r <= 1'b0;
        end
    end

    // Two-entry receive buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_mem_r[0] <= smp_pkg::RST_DATA;
            rx_mem_r[1] <= smp_pkg::RST_DATA;
            wp_r        <= 1'b0;
            rp_r        <= 1'b0;
            rx_cnt_r    <= 2'h0;
        end else begin
            if (push) begin
                rx_mem_r[wp_r] <= rx_sh_nxt;
                wp_r           <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            rx_cnt_r <= rx_cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Bus answer, events and registered pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r    <= 1'b0;
            dat_r    <= 32'h0;
            rx_evt_r <= 1'b0;
            tx_evt_r <= 1'b0;
            pins_r   <= {4'h0, 4'hF};
        end else begin
            ack_r    <= acc;
            dat_r    <= acc ? rd_mux : dat_r;
            rx_evt_r <= push;
            tx_evt_r <= load;
            pins_r   <= pins_nxt;
        end
    end

    assign wb_ack_o       = ack_r;
    assign wb_dat_o       = dat_r;
    assign rx_ready_evt_o = rx_evt_r;
    assign tx_empty_evt_o = tx_evt_r;
    assign pin_o          = pins_r.lvl;
    assign pin_oe_n_o     = pins_r.oe_n;

endmodule : smp_spi_port

`default_nettype wire

// file: test/smp_chk.sv
// Port-level checker of the serial byte port, bound to the top module.
// Assumes pins are registered one cycle behind register writes.
`default_nettype none

module smp_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  pin_o,
    input wire logic [3:0]  pin_oe_n_o,
    input wire logic        rx_ready_evt_o,
    input wire logic        tx_empty_evt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cfg_r;
    logic [3:0] clm_r;
    logic       sck_r;
    logic [4:0] edg_r;
    logic [7:0] cnt_r;
    wire logic       wr  = wb_ack_o & wb_we_i & wb_sel_i[0];
    wire logic       mst = cfg_r[5:4] == 2'h1;
    wire logic       chg = pin_o[3] != sck_r;
    wire logic [7:0] hf  = cfg_r[1] ? (cfg_r[0] ? 8'h30 : 8'h18) : (cfg_r[0] ? 8'h06 : 8'h03);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Shadow of config and claim registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= 8'h00;
            clm_r <= 4'h0;
        end else if (wr && wb_adr_i[7:2] == 6'h3D) begin
            cfg_r <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i[7:2] == 6'h3F) begin
            clm_r <= wb_dat_i[3:0];
        end
    end

    // Serial clock edge and spacing counters
    always_ff @(posedge clk_i) begin
        sck_r <= pin_o[3];
        cnt_r <= (rst_i || chg) ? 8'h00 : cnt_r + 8'h01;
        edg_r <= (rst_i || pin_o[1]) ? 5'h00 : edg_r + 5'(chg);
    end

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_cfg;
        wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h3D |-> wb_dat_o == {24'h0, cfg_r};
    endproperty
    a_cfg: assert property (p_cfg) else $error("config readback wrong");
    property p_idle;
        mst && clm_r[3] && clm_r[1] && pin_o[1] && $stable(cfg_r) |->
            pin_o[3] == cfg_r[3] && !pin_oe_n_o[3];
    endproperty
    a_idle: assert property (p_idle) else $error("clock idle level wrong");
    property p_div;
        mst && clm_r[3] && clm_r[1] && !pin_o[1] && chg && edg_r != 5'h00 |-> cnt_r == hf - 8'h01;
    endproperty
    a_div: assert property (p_div) else $error("clock half period wrong");
    property p_rx;
        mst && clm_r[1] && clm_r[3] && !pin_o[1] && chg && edg_r == 5'h0F |->
            ##[0:1] rx_ready_evt_o;
    endproperty
    a_rx: assert property (p_rx) else $error("no receive event");
    property p_tx;
        mst && clm_r[1] && tx_empty_evt_o |-> ##[0:2] !pin_o[1];
    endproperty
    a_tx: assert property (p_tx) else $error("empty event outside frame");
    property p_swap;
        mst && clm_r[0] && clm_r[2] |-> pin_oe_n_o[0] == cfg_r[7] && pin_oe_n_o[2] != cfg_r[7];
    endproperty
    a_swap: assert property (p_swap) else $error("data pin roles wrong");
    property p_slv;
        cfg_r[5:4] == 2'h2 && clm_r[3] |-> pin_oe_n_o[3];
    endproperty
    a_slv: assert property (p_slv) else $error("slave drives clock");
endmodule : smp_chk

bind smp_spi_port smp_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_o, .pin_oe_n_o, .rx_ready_evt_o,
    .tx_empty_evt_o);

`default_nettype wire

// file: test/smp_spi_slave_model.sv
// Behavioural far-end slave on the four-wire serial link.
// Assumes an active-low select; the bench routes the data lines.
`default_nettype none

module smp_spi_slave_model (
    input  wire logic       sclk_i,
    input  wire logic       sel_n_i,
    input  wire logic       din_i,
    input  wire logic       lsb_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic [7:0] tx_i,
    output logic            dout_o,
    output logic      [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int k;

    task automatic put;
        if (k >= 0 && k < 8) dout_o = lsb_i ? tx_i[k] : tx_i[7 - k];
        else dout_o = ~dout_o;
    endtask : put

    initial dout_o = 1'b0;
    always @(negedge sel_n_i) begin
        k = cpha_i ? -1 : 0;
        put();
    end
    always @(posedge sel_n_i) dout_o = ~dout_o;
    always @(sclk_i) begin
        if (!sel_n_i && (sclk_i ^ cpol_i ^ cpha_i)) begin
            rx_o = lsb_i ? {din_i, rx_o[7:1]} : {rx_o[6:0], din_i};
        end else if (!sel_n_i) begin
            k++;
            put();
        end
    end
endmodule : smp_spi_slave_model

`default_nettype wire

// file: test/test_spi_master_slave_port.sv
// Self-checking bench of the serial byte port in master role.
// Assumes the slave model on the link and pulled-up released lines.
`default_nettype none

module test_spi_master_slave_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dw    = 32'h0;
    logic [3:0]  plv   = 4'h2;
    logic [3:0]  poe   = 4'hD;
    logic [7:0]  cfg   = 8'h00;
    logic [7:0]  stx   = 8'h00;
    logic [7:0]  txb   = 8'h00;
    logic [7:0]  h0, h1, mrx;
    logic [31:0] seed  = 32'h4CC6;
    logic [31:0] dat;
    logic        ack, rxe, sd;
    logic [3:0]  po, oe;
    logic [7:0]  exq[$];
    int          errors  = 0;
    int          checked = 0;
    wire logic       sw    = cfg[7];
    wire logic       sel_w = oe[1] | po[1];
    wire logic [3:0] pw;

    for (genvar i = 0; i < 4; i++) begin : g_pin
        assign pw[i] = !oe[i] ? po[i] : (i == (sw ? 0 : 2) && !sel_w) ? sd : 1'b1;
    end

    always #50 clk_i = ~clk_i;

    smp_spi_port uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dat),
        .wb_ack_o(ack), .pin_i(pw), .pin_o(po), .pin_oe_n_o(oe), .port_lvl_i(plv),
        .port_oe_n_i(poe), .rx_ready_evt_o(rxe), .tx_empty_evt_o());
    smp_spi_slave_model u_peer (.sclk_i(pw[3]), .sel_n_i(sel_w), .din_i(sw ? pw[2] : pw[0]),
        .lsb_i(cfg[6]), .cpol_i(cfg[3]), .cpha_i(cfg[2]), .tx_i(stx), .dout_o(sd), .rx_o(mrx));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dw  <= {24'h0, d};
        if (!w) exq.push_back(d);
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask : bus

    task automatic snd;
        seed = xs(seed);
        stx  = seed[15:8];
        txb  = seed[7:0];
        bus(1'b1, 8'hF0, txb);
    endtask : snd

    task automatic fin(input logic rd);
        while (rxe !== 1'b1) begin
            @(posedge clk_i);
        end
        check(mrx, txb);
        if (rd) bus(1'b0, 8'hF0, stx);
    endtask : fin

    task automatic finish_test;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Read results matched against notes in order
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we) begin
            if (exq.size() == 0) errors++;
            else check(dat[7:0], exq.pop_front());
        end
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'hF0, 8'h00);
        bus(1'b0, 8'hF4, 8'h00);
        bus(1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'hFC, 8'h0F);
        poe <= 4'hF;
        bus(1'b1, 8'hF4, 8'h20);
        bus(1'b0, 8'hF4, 8'h20);
        poe <= 4'hD;
        for (int i = 0; i < 8; i++) begin
            cfg = {i[2], i[0], 2'h1, i[1], i[2] ^ i[0], i[1:0]};
            bus(1'b1, 8'hF4, cfg);
            bus(1'b0, 8'hF4, cfg);
            snd();
            fin(1'b1);
        end
        snd();
        fin(1'b0);
        h0 = stx;
        snd();
        fin(1'b0);
        h1 = stx;
        snd();
        bus(1'b0, 8'hF8, 8'h06);
        bus(1'b0, 8'hF0, h0);
        bus(1'b0, 8'hF0, h1);
        fin(1'b1);
        finish_test();
    end
endmodule : test_spi_master_slave_port

`default_nettype wire
